/* src/adcctl_top.sv */
// Purpose: converter control, reference and channel select, port gating
// Assumes: analog mux and comparator are outside; all inputs synchronous
// Notes: one TAD is TAD_CYC clocks; a conversion takes CONV_TADS TADs
`timescale 1ns/1ns
module adcctl_top import adcctl_pkg::*; #(
  parameter int unsigned NUM_CH = 16,
  parameter int unsigned CH_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Converter control
  input wire logic enable,
  input wire logic start_set,
  input wire logic start_clr,
  input wire logic [CH_W-1:0] channel_select,
  input wire logic [REF_W-1:0] pos_ref_select,
  input wire logic [REF_W-1:0] neg_ref_select,
  input wire logic [ACQ_W-1:0] acquisition_time_sel_wr,
  input wire logic acq_sel_we,
  input wire logic result_justify,
  input wire logic done_flag_clr,
  input wire logic done_irq_en,
  // Comparator
  input wire logic cmp_above,
  // Port B analog select
  input wire logic portb_analog_reset_cfg,
  input wire logic [PORT_W-1:0] portb_analog_select_wr,
  input wire logic portb_analog_select_we,
  // Port pins
  input wire logic [PORT_W-1:0] pin_direction,
  input wire logic [PORT_W-1:0] pin_out_level,
  input wire logic [PORT_W-1:0] pin_in_level,
  // Status
  output logic busy_q,
  output logic conversion_done_flag_q,
  output logic done_irq_q,
  output logic wake_q,
  output logic [ACQ_W-1:0] acquisition_time_sel_q,
  output logic [PORT_W-1:0] result_high_q,
  output logic [PORT_W-1:0] result_low_q,
  // Analog routing
  output logic [NUM_CH-1:0] ch_onehot_q,
  output logic sample_q,
  output logic [2:0] pos_ref_onehot_q,
  output logic [1:0] neg_ref_onehot_q,
  // Port gating
  output logic [PORT_W-1:0] portb_analog_select_reg_q,
  output logic [PORT_W-1:0] in_buf_en_q,
  output logic [PORT_W-1:0] out_drv_en_q,
  output logic [PORT_W-1:0] pin_out_q,
  output logic [PORT_W-1:0] port_read_q
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  adcctl_state_e state_q;
  adcctl_state_e state_d;
  logic [CNT_W-1:0] tad_cnt_q;
  logic tad_tick;
  logic [4:0] phase_q;
  logic [3:0] bit_q;
  logic [4:0] acq_tads;
  logic sar_load;
  logic sar_step;
  logic [RES_W-1:0] sar_value;
  logic conv_done;
  logic go;
  logic abort;
  logic acq_end;
  logic strap_taken_q;

  // Manual code skips acquisition and converts at once
  function automatic logic acq_is_manual(input logic [ACQ_W-1:0] sel);
    return sel == ACQ_MANUAL;
  endfunction

  assign acq_tads = adcctl_acq_tads(acquisition_time_sel_q);
  assign go = start_set && enable && (state_q == ADCCTL_IDLE);
  assign abort = start_clr || !enable;
  assign tad_tick = (tad_cnt_q == TAD_LAST);
  // Conversion ends when the last bit has been resolved
  assign conv_done = (state_q == ADCCTL_CONV) && tad_tick && (bit_q == 4'h0) && !abort;
  // Last acquisition TAD hands over to conversion
  assign acq_end = (state_q == ADCCTL_ACQ) && tad_tick && (phase_q == 5'h01);
  assign sar_load = go || acq_end;
  assign sar_step = (state_q == ADCCTL_CONV) && tad_tick && (phase_q == 5'h00);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ADCCTL_IDLE: begin
        if (go) begin
          // Manual acquisition goes straight to conversion
          state_d = acq_is_manual(acquisition_time_sel_q) ? ADCCTL_CONV : ADCCTL_ACQ;
        end
      end
      ADCCTL_ACQ: begin
        if (abort) begin
          state_d = ADCCTL_GAP;
        end else if (acq_end) begin
          state_d = ADCCTL_CONV;
        end
      end
      ADCCTL_CONV: begin
        if (abort || conv_done) begin
          state_d = ADCCTL_GAP;
        end
      end
      ADCCTL_GAP: begin
        if (tad_tick && phase_q[3:0] == GAP_LAST) begin
          state_d = ADCCTL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ADCCTL_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tad_cnt_q <= '0;
    end else if (state_q != state_d || state_q == ADCCTL_IDLE || tad_tick) begin
      tad_cnt_q <= '0;
    end else begin
      tad_cnt_q <= tad_cnt_q + CNT_W'(1);
    end
  end

  // Phase: acquisition countdown, conversion sub-step, or gap count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= 5'h00;
      bit_q <= 4'h0;
    end else if (go) begin
      phase_q <= acq_is_manual(acquisition_time_sel_q) ? 5'h01 : acq_tads;
      bit_q <= CONV_BIT_LAST;
    end else if (state_q != state_d) begin
      phase_q <= (state_d == ADCCTL_CONV) ? 5'h01 : 5'h00;
      bit_q <= CONV_BIT_LAST;
    end else if (tad_tick) begin
      unique case (state_q)
        ADCCTL_ACQ: phase_q <= phase_q - 5'h01;
        ADCCTL_CONV: begin
          // First TAD of conversion disconnects the hold cap
          if (phase_q != 5'h00) begin
            phase_q <= 5'h00;
          end else begin
            bit_q <= bit_q - 4'h1;
          end
        end
        ADCCTL_GAP: phase_q <= phase_q + 5'h01;
        default: phase_q <= phase_q;
      endcase
    end
  end

  adcctl_sar u_sar (
    .clk(clk),
    .rst(rst),
    .load(sar_load),
    .step(sar_step),
    .bit_idx(bit_q),
    .cmp_above(cmp_above),
    .value_q(sar_value)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control and status bits

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acquisition_time_sel_q <= ACQ_RESET;
    end else if (acq_sel_we) begin
      acquisition_time_sel_q <= acquisition_time_sel_wr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d == ADCCTL_ACQ) || (state_d == ADCCTL_CONV);
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conversion_done_flag_q <= 1'b0;
    end else if (conv_done) begin
      conversion_done_flag_q <= 1'b1;
    end else if (done_flag_clr) begin
      conversion_done_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      done_irq_q <= done_irq_en && (conv_done || (conversion_done_flag_q && !done_flag_clr));
      wake_q <= done_irq_en && conv_done;
    end
  end

  // Aborted conversions keep the previous result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_high_q <= '0;
      result_low_q <= '0;
    end else if (conv_done) begin
      // Final bit is resolved this cycle; fold it in
      if (result_justify) begin
        result_high_q <= {6'h00, sar_value[9:8]};
        result_low_q <= {sar_value[7:1], cmp_above};
      end else begin
        result_high_q <= sar_value[9:2];
        result_low_q <= {sar_value[1], cmp_above, 6'h00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog routing

  // Sampling in idle and acquisition while enabled, not in the gap; gating bits do not affect it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch_onehot_q <= '0;
      sample_q <= 1'b0;
    end else begin
      ch_onehot_q <= enable ? (NUM_CH'(1) << channel_select) : '0;
      sample_q <= enable && (state_d == ADCCTL_IDLE || state_d == ADCCTL_ACQ);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_ref_onehot_q <= 3'h1;
      neg_ref_onehot_q <= 2'h1;
    end else begin
      unique case (pos_ref_select)
        PREF_EXT: pos_ref_onehot_q <= 3'h4;
        PREF_FIXED: pos_ref_onehot_q <= 3'h2;
        default: pos_ref_onehot_q <= 3'h1;
      endcase
      neg_ref_onehot_q <= (neg_ref_select == NREF_EXT) ? 2'h2 : 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port gating

  // Configuration strap caught once after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      portb_analog_select_reg_q <= PORTB_ALL_ANALOG;
    end else if (portb_analog_select_we) begin
      portb_analog_select_reg_q <= portb_analog_select_wr;
    end else if (!strap_taken_q) begin
      portb_analog_select_reg_q <= portb_analog_reset_cfg ? PORTB_ALL_ANALOG
                                                         : PORTB_ALL_DIGITAL;
    end
  end

  // Gating follows last cycle's select and direction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_buf_en_q <= '0;
      out_drv_en_q <= '0;
      pin_out_q <= '0;
      port_read_q <= '0;
    end else begin
      in_buf_en_q <= ~portb_analog_select_reg_q;
      // Driver stays on for analog pins with direction cleared
      out_drv_en_q <= ~pin_direction;
      pin_out_q <= pin_out_level;
      port_read_q <= pin_in_level & ~portb_analog_select_reg_q;
    end
  end

endmodule // adcctl_top

/* shared/adcctl_pkg.sv */
// Purpose: constants for the converter control and port gating block
// Assumes: 20 MHz system clock, one clock domain
// Notes: field encodings and timing counts live here
package adcctl_pkg;

  localparam int unsigned RES_W = 10;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ACQ_W = 3;
  localparam int unsigned REF_W = 2;
  localparam int unsigned CNT_W = 8;

  localparam logic [ACQ_W-1:0] ACQ_MANUAL = 3'h0;
  localparam logic [ACQ_W-1:0] ACQ_RESET = ACQ_MANUAL;

  localparam logic [REF_W-1:0] PREF_SUPPLY = 2'h0;
  localparam logic [REF_W-1:0] PREF_EXT = 2'h1;
  localparam logic [REF_W-1:0] PREF_FIXED = 2'h2;
  localparam logic [REF_W-1:0] NREF_GROUND = 2'h0;
  localparam logic [REF_W-1:0] NREF_EXT = 2'h1;

  // Conversion clock period and derived counts
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TAD_NS = 1000;
  localparam int unsigned TAD_CYC = (TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_TADS = 11;
  localparam int unsigned GAP_TADS = 2;

  localparam logic [CNT_W-1:0] TAD_LAST = CNT_W'(TAD_CYC - 1);
  localparam logic [3:0] CONV_BIT_LAST = 4'(RES_W - 1);
  localparam logic [3:0] CONV_START_BIT = 4'(RES_W);
  localparam logic [3:0] GAP_LAST = 4'(GAP_TADS - 1);

  localparam logic [PORT_W-1:0] PORTB_ALL_ANALOG = 8'hff;
  localparam logic [PORT_W-1:0] PORTB_ALL_DIGITAL = 8'h00;
  localparam logic [RES_W-1:0] RES_ZERO = 10'h000;
  localparam logic [RES_W-1:0] RES_HALF = 10'h200;

  typedef enum logic [1:0] {
    ADCCTL_IDLE = 2'b00,
    ADCCTL_ACQ = 2'b01,
    ADCCTL_CONV = 2'b11,
    ADCCTL_GAP = 2'b10
  } adcctl_state_e;

  // Acquisition time in TAD for the non-manual codes
  function automatic logic [4:0] adcctl_acq_tads(input logic [ACQ_W-1:0] sel);
    logic [4:0] n;
    n = 5'h00;
    unique case (sel)
      3'h0: n = 5'h00;
      3'h1: n = 5'h02;
      3'h2: n = 5'h04;
      3'h3: n = 5'h06;
      3'h4: n = 5'h08;
      3'h5: n = 5'h0c;
      3'h6: n = 5'h10;
      3'h7: n = 5'h14;
    endcase
    return n;
  endfunction

endpackage

/* src/adcctl_sar.sv */
// Purpose: successive approximation register for the converter
// Assumes: comparator input is synchronous and valid during each step
// Notes: trial bit moves one place per step pulse
`timescale 1ns/1ns
module adcctl_sar import adcctl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic step,
  input wire logic [3:0] bit_idx,
  input wire logic cmp_above,
  // Result
  output logic [RES_W-1:0] value_q
);

  logic [RES_W-1:0] value_d;

  always_comb begin
    value_d = value_q;
    if (load) begin
      value_d = RES_HALF;
    end else if (step) begin
      // Keep trial bit if input is above, then try the next one
      value_d[bit_idx] = cmp_above;
      if (bit_idx != 4'h0) begin
        value_d[bit_idx - 4'h1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_q <= RES_ZERO;
    end else begin
      value_q <= value_d;
    end
  end

endmodule // adcctl_sar

/* testbench/adcctl_props.sv */
// Purpose: port assertions for adcctl_top
// Assumes: one clock, async active-high reset
// Notes: bound at the foot of this file
`timescale 1ns/1ns
module adcctl_props import adcctl_pkg::*; #(
  parameter int unsigned NUM_CH = 16,
  parameter int unsigned CH_W = 4
) (
  // Clock, reset, control
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [CH_W-1:0] channel_select,
  input wire logic [REF_W-1:0] pos_ref_select,
  input wire logic done_flag_clr,
  input wire logic done_irq_en,
  // Watched outputs
  input wire logic busy_q,
  input wire logic conversion_done_flag_q,
  input wire logic wake_q,
  input wire logic [ACQ_W-1:0] acquisition_time_sel_q,
  input wire logic [PORT_W-1:0] result_high_q,
  input wire logic [PORT_W-1:0] result_low_q,
  input wire logic [NUM_CH-1:0] ch_onehot_q,
  input wire logic [2:0] pos_ref_onehot_q,
  input wire logic [PORT_W-1:0] portb_analog_select_reg_q,
  input wire logic [PORT_W-1:0] in_buf_en_q,
  input wire logic [PORT_W-1:0] port_read_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [8:0] busy_cnt_q;
  // Cycles spent busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busy_cnt_q <= 9'h000;
    else busy_cnt_q <= busy_q ? busy_cnt_q + 9'h001 : 9'h000;
  end
  a_channel_onehot: assert property (
    enable |=> ch_onehot_q == NUM_CH'(1) << $past(channel_select))
    else $error("bad channel one-hot");
  a_pos_ref_map: assert property (
    ##1 pos_ref_onehot_q == ($past(pos_ref_select) == PREF_EXT ? 3'h4 :
    $past(pos_ref_select) == PREF_FIXED ? 3'h2 : 3'h1))
    else $error("bad reference one-hot");
  a_input_gate: assert property (
    ##1 in_buf_en_q == ~$past(portb_analog_select_reg_q))
    else $error("bad input buffer enable");
  a_read_zero: assert property (
    (port_read_q & portb_analog_select_reg_q & $past(portb_analog_select_reg_q)) == '0)
    else $error("analog pin reads high");
  a_conv_length: assert property (
    $fell(busy_q) && $rose(conversion_done_flag_q) && acquisition_time_sel_q == ACQ_MANUAL
    |-> busy_cnt_q == 9'h0dc)
    else $error("bad conversion length");
  a_flag_sticky: assert property (
    conversion_done_flag_q && !done_flag_clr |=> conversion_done_flag_q)
    else $error("done flag lost");
  a_wake_pulse: assert property (
    $rose(conversion_done_flag_q) && $past(done_irq_en) |-> wake_q ##1 !wake_q)
    else $error("bad wake pulse");
  a_result_hold: assert property (
    !$stable({result_high_q, result_low_q}) |-> $fell(busy_q))
    else $error("result moved outside completion");
  c_done: cover property ($rose(conversion_done_flag_q));
  c_wake: cover property (wake_q);
  c_abort: cover property ($fell(busy_q) && !conversion_done_flag_q);
endmodule // adcctl_props

bind adcctl_top adcctl_props #(.NUM_CH(NUM_CH), .CH_W(CH_W)) u_props (
  .clk(clk), .rst(rst), .enable(enable), .channel_select(channel_select),
  .pos_ref_select(pos_ref_select), .done_flag_clr(done_flag_clr), .done_irq_en(done_irq_en),
  .busy_q(busy_q), .conversion_done_flag_q(conversion_done_flag_q), .wake_q(wake_q),
  .acquisition_time_sel_q(acquisition_time_sel_q), .result_high_q(result_high_q),
  .result_low_q(result_low_q), .ch_onehot_q(ch_onehot_q), .pos_ref_onehot_q(pos_ref_onehot_q),
  .portb_analog_select_reg_q(portb_analog_select_reg_q), .in_buf_en_q(in_buf_en_q),
  .port_read_q(port_read_q)
);

/* testbench/adcctl_pins_model.sv */
// Purpose: pad and comparator model facing adcctl_top
// Assumes: comparator gives the held level MSB first, one bit per TAD
// Notes: idle comparator line toggles every cycle
`timescale 1ns/1ns
module adcctl_pins_model import adcctl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Block side
  input wire logic busy_q,
  input wire logic [15:0] ch_onehot_q,
  input wire logic [PORT_W-1:0] out_drv_en_q,
  input wire logic [PORT_W-1:0] pin_out_q,
  output logic [PORT_W-1:0] pin_in_level,
  output logic cmp_above,
  // Pad side
  input wire logic [PORT_W-1:0] pad_ext,
  input wire logic [15:0][RES_W-1:0] ana
);
  logic [9:0] cnt_q;
  logic [RES_W-1:0] held_q, sel_v;
  logic idle_q;
  int bit_n;
  assign pin_in_level = (out_drv_en_q & pin_out_q) | (~out_drv_en_q & pad_ext);
  always_comb begin
    sel_v = ~held_q;
    for (int i = 0; i < 16; i++) begin
      if (ch_onehot_q[i]) sel_v = ana[i];
    end
    for (int i = 0; i < PORT_W; i++) begin
      if (ch_onehot_q[i] && out_drv_en_q[i]) sel_v = {RES_W{pin_out_q[i]}};
    end
    bit_n = cnt_q < 10'h027 ? 0 : (int'(cnt_q) - 39) / 20;
    if (bit_n > 9) bit_n = 9;
    cmp_above = busy_q ? held_q[9-bit_n] : idle_q;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 10'h000;
      held_q <= 10'h000;
      idle_q <= 1'b0;
    end else begin
      cnt_q <= busy_q ? cnt_q + 10'h001 : 10'h000;
      idle_q <= ~idle_q;
      if (!busy_q) held_q <= sel_v;
    end
  end
endmodule // adcctl_pins_model

/* testbench/test_adc_control_and_port_gating.sv */
// Purpose: self-checking bench for adcctl_top
// Assumes: inputs change on the falling edge
// Notes: pads and comparator come from adcctl_pins_model
`timescale 1ns/1ns
module test_adc_control_and_port_gating import adcctl_pkg::*;;
  logic clk, rst, en, go, stop, acq_we, just, clr, irq_en, cmp, strap, sel_we;
  logic busy, flag, irq, wake, smp;
  logic [3:0] ch;
  logic [REF_W-1:0] pref, nref;
  logic [ACQ_W-1:0] acq_wr, acq_q;
  logic [PORT_W-1:0] sel_wr, dir, lvl, pin_in, pad, sel_q, ibuf, odrv, pout, prd, hi, lo;
  logic [15:0] ch_oh;
  logic [2:0] pref_oh;
  logic [1:0] nref_oh;
  logic [15:0][RES_W-1:0] ana;
  int num_errors, checks_done, cycles;

  adcctl_top #(.NUM_CH(16), .CH_W(4)) uut (
    .clk(clk), .rst(rst), .enable(en), .start_set(go), .start_clr(stop),
    .channel_select(ch), .pos_ref_select(pref), .neg_ref_select(nref),
    .acquisition_time_sel_wr(acq_wr), .acq_sel_we(acq_we), .result_justify(just),
    .done_flag_clr(clr), .done_irq_en(irq_en), .cmp_above(cmp),
    .portb_analog_reset_cfg(strap), .portb_analog_select_wr(sel_wr),
    .portb_analog_select_we(sel_we), .pin_direction(dir), .pin_out_level(lvl),
    .pin_in_level(pin_in), .busy_q(busy), .conversion_done_flag_q(flag),
    .done_irq_q(irq), .wake_q(wake), .acquisition_time_sel_q(acq_q),
    .result_high_q(hi), .result_low_q(lo), .ch_onehot_q(ch_oh), .sample_q(smp),
    .pos_ref_onehot_q(pref_oh), .neg_ref_onehot_q(nref_oh),
    .portb_analog_select_reg_q(sel_q), .in_buf_en_q(ibuf), .out_drv_en_q(odrv),
    .pin_out_q(pout), .port_read_q(prd)
  );
  adcctl_pins_model pads (
    .clk(clk), .rst(rst), .busy_q(busy), .ch_onehot_q(ch_oh), .out_drv_en_q(odrv),
    .pin_out_q(pout), .pin_in_level(pin_in), .cmp_above(cmp), .pad_ext(pad), .ana(ana)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset(input logic cfg);
    strap = cfg;
    rst = 1'b1;
    tick(16);
    rst = 1'b0;
    tick(3);
  endtask
  // Channel settles, one start, completion checked, flag cleared
  task automatic convert(input int c, input logic [9:0] v, input logic [9:0] e,
                         input logic j, input int t);
    int n;
    ch = 4'(c);
    ana[c] = v;
    just = j;
    tick(60);
    check_eq(smp, 1'b1);
    go = 1'b1;
    tick(1);
    go = 1'b0;
    check_eq(smp, t > int'(CONV_TADS * TAD_CYC));
    n = 0;
    while (flag !== 1'b1 && n < 800) begin
      tick(1);
      n++;
    end
    check_eq(16'(n), 16'(t));
    check_eq(busy, 1'b0);
    check_eq(hi, j ? {6'h00, e[9:8]} : e[9:2]);
    check_eq(lo, j ? e[7:0] : {e[1:0], 6'h00});
    check_eq({irq, wake}, {irq_en, irq_en});
    tick(45);
    check_eq({flag, wake}, 2'b10);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(1);
    check_eq(flag, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {en, go, stop, acq_we, just, clr, irq_en, strap, sel_we} = '0;
    {ch, pref, nref, acq_wr, sel_wr, lvl} = '0;
    {dir, pad} = 16'hffff;
    ana = '0;
    do_reset(1'b0);
    check_eq({sel_q, prd}, 16'h00ff);
    do_reset(1'b1);
    check_eq({sel_q, ibuf, prd}, 24'hff_0000);
    check_eq(acq_q, 3'h0);
    for (int i = 0; i < 16; i++) begin
      pref = i[1:0];
      nref = i[3:2];
      tick(2);
      check_eq(pref_oh, pref == PREF_EXT ? 3'h4 : pref == PREF_FIXED ? 3'h2 : 3'h1);
      check_eq(nref_oh, nref == NREF_EXT ? 2'h2 : 2'h1);
    end
    tick(2);
    check_eq(ch_oh, 16'h0000);
    en = 1'b1;
    for (int c = 0; c < 16; c++) begin
      ch = 4'(c);
      tick(2);
      check_eq(ch_oh, 16'h0001 << c);
    end
    irq_en = 1'b1;
    convert(3, 10'h2b5, 10'h2b5, 1'b1, 220);
    irq_en = 1'b0;
    convert(3, 10'h2b5, 10'h2b5, 1'b0, 220);
    {dir, lvl} = 16'hfd02;
    convert(1, 10'h155, 10'h3ff, 1'b1, 220);
    dir = 8'hff;
    convert(1, 10'h155, 10'h155, 1'b1, 220);
    {dir, lvl, pad, sel_wr} = 32'h0f3c_99a5;
    sel_we = 1'b1;
    tick(1);
    sel_we = 1'b0;
    tick(3);
    check_eq({sel_q, ibuf, odrv}, 24'ha5_5af0);
    check_eq(prd, 8'h18);
    acq_wr = 3'h2;
    acq_we = 1'b1;
    tick(1);
    acq_we = 1'b0;
    tick(1);
    check_eq(acq_q, 3'h2);
    convert(5, 10'h3ff, 10'h3ff, 1'b1, 300);
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(50);
    stop = 1'b1;
    tick(1);
    stop = 1'b0;
    check_eq(busy, 1'b0);
    tick(300);
    check_eq({flag, hi, lo}, 17'h0_03ff);
    finish_test();
  end
endmodule // test_adc_control_and_port_gating
